// *** rtl/icp_pkg.sv ***
// What this block does
// RULE_01: Four non-overlapping phases from the clock form one instruction cycle.
// RULE_02: Phase one advances the program counter and starts a fetch.
// RULE_03: Phases two to four decode and execute the held instruction.
// RULE_04: Fetch of the next overlaps execution of the current instruction.
// RULE_05: Non-branching instructions complete one per instruction cycle.
// RULE_06: Program counter changes take two cycles: target, then branch.
// RULE_07: One 8-bit ALU with operands and results through the accumulator.
// RULE_08: A satisfied skip discards the prefetched word for a dummy cycle.
// RULE_09: A write to the low byte jumps within the 256 page, with dummy.
// RULE_10: A taken branch cancels the overlapped fetch and resumes at target.
package icp_pkg;
    localparam int PC_W       = 11;
    localparam int INSTR_W    = 15;
    localparam int DATA_W     = 8;
    localparam int PAGE_W     = 8;
    localparam logic [PC_W-1:0]    PC_RESET  = 11'h000;
    localparam logic [PC_W-1:0]    PC_ONE    = 11'h001;
    localparam logic [DATA_W-1:0]  ACC_RESET = 8'h00;
    localparam logic [INSTR_W-1:0] INSTR_NOP = 15'h0000;

    // Phase states, Gray coded around the cycle
    typedef enum logic [1:0] {
        PH_ONE   = 2'b00,
        PH_TWO   = 2'b01,
        PH_THREE = 2'b11,
        PH_FOUR  = 2'b10
    } icp_phase_type;

    // ALU operations
    typedef enum logic [2:0] {
        ALU_PASS = 3'h0,
        ALU_ADD  = 3'h1,
        ALU_SUB  = 3'h2,
        ALU_AND  = 3'h3,
        ALU_OR   = 3'h4,
        ALU_XOR  = 3'h5,
        ALU_INC  = 3'h6,
        ALU_DEC  = 3'h7
    } icp_alu_op_type;

    // Control word from the decoder
    typedef struct packed {
        logic           valid;
        icp_alu_op_type alu_op;
        logic           acc_we;
        logic           branch;
        logic           skip;
        logic           pcl_write;
        logic [PC_W-1:0] target;
        logic [DATA_W-1:0] operand;
    } icp_exec_type;

    // Phase strobes driven to the datapath
    typedef struct packed {
        logic phase_one_fetch;
        logic phase_two;
        logic phase_three;
        logic phase_four;
    } icp_phases_type;
endpackage : icp_pkg

// *** rtl/icp_pipeline.sv ***
`timescale 1ns/10ps
`default_nettype none
module icp_pipeline (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic [icp_pkg::INSTR_W-1:0]  instr_word,
    input  wire icp_pkg::icp_exec_type        exec_ctrl,
    input  wire logic                         skip_cond,
    output var  logic [icp_pkg::PC_W-1:0]     fetch_addr,
    output var  logic                         fetch_req,
    output var  logic [icp_pkg::INSTR_W-1:0]  instr_held,
    output var  logic                         instr_valid,
    output var  icp_pkg::icp_phases_type      phases,
    output var  logic                         phases_decode_execute,
    output var  logic [icp_pkg::DATA_W-1:0]   acc,
    output var  logic                         retire
);
    import icp_pkg::*;

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    icp_phase_type phase_q;
    icp_phase_type phase_d;
    icp_phases_type phases_d;

    always_comb begin
        case (phase_q)
            PH_ONE:   phase_d = PH_TWO;
            PH_TWO:   phase_d = PH_THREE;
            PH_THREE: phase_d = PH_FOUR;
            PH_FOUR:  phase_d = PH_ONE;
            default:  phase_d = PH_ONE;
        endcase
    end

    // One-hot strobes of the coming phase
    assign phases_d = '{phase_one_fetch: phase_d == PH_ONE,
                        phase_two:       phase_d == PH_TWO,
                        phase_three:     phase_d == PH_THREE,
                        phase_four:      phase_d == PH_FOUR};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= PH_FOUR;
            phases  <= '0;
            phases_decode_execute <= 1'b0;
        end else begin
            phase_q <= phase_d; // RULE_01
            phases  <= phases_d;
            phases_decode_execute <= !phases_d.phase_one_fetch; // RULE_03
        end
    end

    // ************************************************************
    // Control decisions at the end of phase four
    // ************************************************************
    logic              cycle_end;
    logic              redirect;
    logic              run_q;
    logic [PC_W-1:0]   pc_q;
    logic [PC_W-1:0]   pc_d;
    logic [PC_W-1:0]   pc_page_jump;
    logic [PC_W-1:0]   pc_inc;
    logic              live;

    // Release edge only starts phase one, no cycle ends there
    assign cycle_end = (phase_q == PH_FOUR) && run_q;
    assign live      = instr_valid && exec_ctrl.valid;
    assign redirect  = live && (exec_ctrl.branch || exec_ctrl.pcl_write ||
                               (exec_ctrl.skip && skip_cond));
    assign pc_page_jump = {pc_q[PC_W-1:PAGE_W],
                           exec_ctrl.target[PAGE_W-1:0]};
    assign pc_inc = pc_q + PC_ONE;

    // Next fetch address chosen by the finishing instruction
    always_comb begin
        if (live && exec_ctrl.branch)
            pc_d = exec_ctrl.target; // RULE_06
        else if (live && exec_ctrl.pcl_write)
            pc_d = pc_page_jump; // RULE_09
        else
            pc_d = pc_inc; // RULE_02
    end

    // ************************************************************
    // Fetch and overlap registers
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_q        <= PC_RESET;
            fetch_addr  <= PC_RESET;
            fetch_req   <= 1'b0;
            run_q       <= 1'b0;
        end else begin
            run_q     <= 1'b1;
            fetch_req <= phases_d.phase_one_fetch;
            if (cycle_end) begin
                fetch_addr <= pc_d; // RULE_10
                pc_q       <= pc_d; // RULE_02
            end
        end
    end

    // Word fetched during this cycle moves in at its end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            instr_held  <= INSTR_NOP;
            instr_valid <= 1'b0;
        end else if (cycle_end) begin
            instr_held  <= (redirect) ? INSTR_NOP : instr_word; // RULE_04
            instr_valid <= !redirect; // RULE_08
        end
    end

    // ************************************************************
    // ALU and accumulator
    // ************************************************************
    logic [DATA_W-1:0] alu_out;

    always_comb begin
        case (exec_ctrl.alu_op)
            ALU_PASS: alu_out = exec_ctrl.operand;
            ALU_ADD:  alu_out = acc + exec_ctrl.operand;
            ALU_SUB:  alu_out = acc - exec_ctrl.operand;
            ALU_AND:  alu_out = acc & exec_ctrl.operand;
            ALU_OR:   alu_out = acc | exec_ctrl.operand;
            ALU_XOR:  alu_out = acc ^ exec_ctrl.operand;
            ALU_INC:  alu_out = acc + 8'h01;
            ALU_DEC:  alu_out = acc - 8'h01;
            default:  alu_out = acc;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc    <= ACC_RESET;
            retire <= 1'b0;
        end else begin
            if (cycle_end && live && exec_ctrl.acc_we)
                acc <= alu_out; // RULE_07
            retire <= cycle_end && live; // RULE_05
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_phase_cycle;
        @(posedge clk) disable iff (rst)
        phases.phase_one_fetch |=> !phases.phase_one_fetch [*3]
            ##1 phases.phase_one_fetch;
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) // RULE_01
        else $error("phase one not every fourth clock");

    property p_onehot;
        @(posedge clk) disable iff (rst)
        !$past(rst) |-> $onehot(phases);
    endproperty
    a_onehot: assert property (p_onehot) // RULE_01
        else $error("phases overlap");

    property p_fetch_phase;
        @(posedge clk) disable iff (rst)
        fetch_req == phases.phase_one_fetch;
    endproperty
    a_fetch_phase: assert property (p_fetch_phase) // RULE_02
        else $error("fetch outside phase one");

    property p_exec_phase;
        @(posedge clk) disable iff (rst)
        phases_decode_execute |-> !fetch_req;
    endproperty
    a_exec_phase: assert property (p_exec_phase) // RULE_03
        else $error("execute overlaps phase one");

    property p_seq_pc;
        @(posedge clk) disable iff (rst)
        cycle_end && live && !redirect |=> pc_q == $past(pc_q) + PC_ONE;
    endproperty
    a_seq_pc: assert property (p_seq_pc) // RULE_04
        else $error("pc did not advance by one");

    property p_retire;
        @(posedge clk) disable iff (rst)
        cycle_end && live |=> retire;
    endproperty
    a_retire: assert property (p_retire) // RULE_05
        else $error("live instruction did not retire");

    property p_branch_dummy;
        @(posedge clk) disable iff (rst)
        cycle_end && redirect |=> !instr_valid ##4 !retire;
    endproperty
    a_branch_dummy: assert property (p_branch_dummy) // RULE_06
        else $error("no dummy cycle after redirect");

    property p_branch_target;
        @(posedge clk) disable iff (rst)
        cycle_end && live && exec_ctrl.branch
            |=> fetch_addr == $past(exec_ctrl.target);
    endproperty
    a_branch_target: assert property (p_branch_target) // RULE_10
        else $error("fetch did not resume at target");

    property p_page_jump;
        @(posedge clk) disable iff (rst)
        cycle_end && live && exec_ctrl.pcl_write && !exec_ctrl.branch
            |=> pc_q[PC_W-1:PAGE_W] == $past(pc_q[PC_W-1:PAGE_W]);
    endproperty
    a_page_jump: assert property (p_page_jump) // RULE_09
        else $error("low byte jump left the page");

    property p_skip;
        @(posedge clk) disable iff (rst)
        cycle_end && live && exec_ctrl.skip && skip_cond |=> !instr_valid;
    endproperty
    a_skip: assert property (p_skip) // RULE_08
        else $error("skip did not discard prefetch");

    property p_acc_hold;
        @(posedge clk) disable iff (rst)
        !cycle_end |=> $stable(acc);
    endproperty
    a_acc_hold: assert property (p_acc_hold) // RULE_07
        else $error("acc changed mid cycle");

    property p_cov_branch;
        @(posedge clk) cycle_end && live && exec_ctrl.branch;
    endproperty
    c_branch: cover property (p_cov_branch);

    property p_cov_skip;
        @(posedge clk) cycle_end && live && exec_ctrl.skip && skip_cond;
    endproperty
    c_skip: cover property (p_cov_skip);

    property p_cov_run;
        @(posedge clk) retire ##4 retire ##4 retire;
    endproperty
    c_run: cover property (p_cov_run);
endmodule : icp_pipeline
`default_nettype wire

// *** dv/icp_prog_mem.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Program memory model
// ********
module icp_prog_mem #(
    parameter bit SLOW = 1'b0
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [icp_pkg::PC_W-1:0]    fetch_addr,
    input  wire icp_pkg::icp_phases_type     phases,
    output var  logic [icp_pkg::INSTR_W-1:0] instr_word
);
    import icp_pkg::*;
    logic [INSTR_W-1:0] last_q;
    logic               ready;
    // Word valid only late in the cycle, junk before
    assign ready = phases.phase_four | (!SLOW & phases.phase_three);
    assign instr_word = ready ? {4'hA, fetch_addr} : ~last_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_q <= 15'h0000;
        end else if (ready) begin
            last_q <= instr_word;
        end
    end
endmodule : icp_prog_mem
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// ********
// Pipeline bench
// ********
module tb;
    import icp_pkg::*;
    typedef struct packed {
        icp_alu_op_type op;
        logic [7:0]     opnd;
        logic [7:0]     res;
    } icp_row_type;
    typedef struct packed {
        logic [3:0]      fl;
        logic            sk;
        logic [PC_W-1:0] tgt;
        logic [PC_W-1:0] dst;
    } icp_redir_type;
    localparam icp_row_type ROWS [9] = '{
        '{ALU_PASS, 8'h3C, 8'h3C}, '{ALU_ADD, 8'h05, 8'h41},
        '{ALU_SUB, 8'h11, 8'h30}, '{ALU_AND, 8'hF0, 8'h30},
        '{ALU_OR, 8'h05, 8'h35}, '{ALU_XOR, 8'hFF, 8'hCA},
        '{ALU_INC, 8'h00, 8'hCB}, '{ALU_DEC, 8'h00, 8'hCA},
        '{ALU_ADD, 8'hFF, 8'hC9}};
    // Flags are acc_we, branch, skip, pcl_write
    localparam icp_redir_type REDS [4] = '{
        '{4'h4, 1'b0, 11'h123, 11'h123}, '{4'h1, 1'b0, 11'h645, 11'h145},
        '{4'h5, 1'b0, 11'h3F0, 11'h3F0}, '{4'h2, 1'b1, 11'h000, 11'h3F2}};
    logic               clk = 1'b0;
    logic               rst;
    logic [INSTR_W-1:0] instr_word;
    icp_exec_type       exec_ctrl;
    logic               skip_cond;
    logic [PC_W-1:0]    fetch_addr;
    logic               fetch_req;
    logic [INSTR_W-1:0] instr_held;
    logic               instr_valid;
    icp_phases_type     phases;
    logic               phases_decode_execute;
    logic [DATA_W-1:0]  acc;
    logic               retire;
    int                 n_fail = 0;
    int                 tests_run = 0;
    int                 n_ret = 0;
    int                 a;

    icp_pipeline dut (.clk(clk), .rst(rst), .instr_word(instr_word),
        .exec_ctrl(exec_ctrl), .skip_cond(skip_cond),
        .fetch_addr(fetch_addr), .fetch_req(fetch_req),
        .instr_held(instr_held), .instr_valid(instr_valid),
        .phases(phases), .phases_decode_execute(phases_decode_execute),
        .acc(acc), .retire(retire));
    icp_prog_mem #(.SLOW(1'b1)) mem (.clk(clk), .rst(rst),
        .fetch_addr(fetch_addr), .phases(phases), .instr_word(instr_word));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (retire === 1'b1) begin
            n_ret++;
        end
    end

    function automatic icp_exec_type mk(logic v, icp_alu_op_type op,
            logic [7:0] d, logic [3:0] f, logic [PC_W-1:0] t);
        return '{v, op, f[3], f[2], f[1], f[0], t, d};
    endfunction : mk

    function automatic logic [INSTR_W-1:0] word(logic [PC_W-1:0] x);
        return {4'hA, x};
    endfunction : word

    task automatic check(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    task automatic sync_p1;
        for (int i = 0; i < 8 && phases.phase_one_fetch !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (phases.phase_one_fetch !== 1'b1) begin
            n_fail++;
            stop_test();
        end
    endtask : sync_p1

    // One instruction cycle: control held over phases two to four
    task automatic run(input icp_exec_type c, input logic s);
        sync_p1();
        @(posedge clk);
        exec_ctrl <= c;
        skip_cond <= s;
        repeat (3) @(posedge clk);
        exec_ctrl <= '0;
        skip_cond <= 1'b0;
        #1;
    endtask : run

    initial begin
        rst = 1'b1;
        exec_ctrl = '0;
        skip_cond = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check("addr", fetch_addr, 11'h000);
        check("phases", phases, 4'h0);
        @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            #1;
            check("phases", phases, 4'h8 >> k);
            check("req", fetch_req, k == 0);
            check("dec_ex", phases_decode_execute, k != 0);
        end
        check("valid", instr_valid, 1'b0);
        @(posedge clk);
        #1;
        check("held", instr_held, word(11'h000));
        check("addr", fetch_addr, 11'h001);
        $display("test reset done");
        a = 1;
        n_ret = 0;
        foreach (ROWS[i]) begin
            run(mk(1'b1, ROWS[i].op, ROWS[i].opnd, 4'h8, 11'h000), 1'b0);
            check("acc", acc, ROWS[i].res);
            check("addr", fetch_addr, 16'(a + 1));
            check("held", instr_held, word(PC_W'(a)));
            a++;
        end
        repeat (2) @(posedge clk);
        #1;
        check("retired", 16'(n_ret), 16'd9);
        run(mk(1'b0, ALU_INC, 8'h00, 4'h8, 11'h000), 1'b0);
        check("acc", acc, 8'hC9);
        $display("test rows done");
        foreach (REDS[i]) begin
            run(mk(1'b1, ALU_PASS, 8'h00, REDS[i].fl, REDS[i].tgt),
                REDS[i].sk);
            check("addr", fetch_addr, REDS[i].dst);
            check("valid", instr_valid, 1'b0);
            run(mk(1'b1, ALU_INC, 8'h00, 4'h8, 11'h000), 1'b0);
            check("held", instr_held, word(REDS[i].dst));
            check("acc", acc, 8'hC9);
        end
        check("retired", 16'(n_ret), 16'd13);
        $display("test redirects done");
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
